// ==== test/ddr_sram_clock_and_command_port_asserts.sv ====
// Concurrent checks on the SRAM port pins.
// Assumes the output clock pair shares phase with the input pair.
`timescale 1ns/1ps
module ddr_sram_clock_and_command_port_asserts
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic single_clock_mode,
    input wire logic load_strobe_n,
    input wire logic read_not_write,
    input wire logic [17:0] data_out,
    input wire logic data_oe,
    input wire logic echo_clock
);
    logic [1:0] prev_q;
    logic [4:0] launch_q, launch_d, read_q, read_d;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Ages since the last link clock change and the last read command.
    always_comb
    begin
        launch_d = (launch_q == 5'h1F) ? launch_q : launch_q + 5'h01;
        read_d = (read_q == 5'h1F) ? read_q : read_q + 5'h01;
        if ({k_clk, c_clk} != prev_q)
            launch_d = 5'h00;
        if (k_clk && !prev_q[1] && !load_strobe_n && read_not_write)
            read_d = 5'h00;
    end
    always_ff @(posedge core_clk)
    begin
        prev_q <= {k_clk, c_clk};
        launch_q <= reset ? 5'h1F : launch_d;
        read_q <= reset ? 5'h1F : read_d;
    end
    sequence c_mode_s;
        !single_clock_mode && !$past(single_clock_mode, 8);
    endsequence
    sequence k_mode_s;
        single_clock_mode && $past(single_clock_mode, 8);
    endsequence
    echo_rise_a: assert property (c_mode_s ##0 $rose(c_clk) |-> ##[1:6] echo_clock)
        else $error("echo missed output clock rise");
    echo_fall_a: assert property (c_mode_s ##0 $rose(c_clk_n) |-> ##[1:6] !echo_clock)
        else $error("echo missed negative output clock");
    single_rise_a: assert property (k_mode_s ##0 $rose(k_clk) |-> ##[1:6] echo_clock)
        else $error("echo missed input clock rise");
    single_fall_a: assert property (k_mode_s ##0 $rose(k_clk_n) |-> ##[1:6] !echo_clock)
        else $error("echo missed negative input clock");
    oe_bound_a: assert property (data_oe |-> read_q < 5'h18)
        else $error("data driven outside a read");
    oe_start_a: assert property ($rose(data_oe) |-> read_q <= 5'h0E)
        else $error("data enabled without read command");
    data_move_a: assert property ($changed(data_out) |-> launch_q <= 5'h06)
        else $error("read data moved away from launch edge");
    reset_quiet_a: assert property ($fell(reset) |-> !data_oe && !echo_clock)
        else $error("outputs active out of reset");
endmodule

bind ddr_sram_clock_and_command_port ddr_sram_clock_and_command_port_asserts u_asserts
(
    .core_clk, .reset, .k_clk, .k_clk_n, .c_clk, .c_clk_n, .single_clock_mode,
    .load_strobe_n, .read_not_write, .data_out, .data_oe, .echo_clock
);

// ==== test/link_clock_source.sv ====
// Controller-side clock source for the SRAM port bench.
// Assumes the bench gates the output pair off in single clock mode.
`timescale 1ns/1ps
module link_clock_source
(
    input wire logic out_clk_en,
    output logic k_clk,
    output logic k_clk_n,
    output logic c_clk,
    output logic c_clk_n
);
    initial
    begin
        k_clk = 1'b0;
        #7;
        forever #200 k_clk = ~k_clk;
    end
    assign k_clk_n = ~k_clk;
    assign c_clk = out_clk_en & k_clk;
    assign c_clk_n = out_clk_en & ~k_clk;
endmodule

// ==== test/tb_ddr_sram_clock_and_command_port.sv ====
// Self-checking bench for the DDR SRAM clock and command port.
// Assumes the clock source keeps the output pair in phase with the input pair.
`timescale 1ns/1ps
module tb_ddr_sram_clock_and_command_port;
    logic core_clk, reset, k_clk, k_clk_n, c_clk, c_clk_n, out_clk_en, single_clock_mode;
    logic load_strobe_n, read_not_write, data_oe, echo_clock, echo_clock_n;
    logic [19:0] address;
    logic [1:0] byte_write_select_n;
    logic [17:0] data_in, data_out;
    int failures = 0;
    int n_checks = 0;
    int cycle_count = 0;
    link_clock_source u_link (.out_clk_en, .k_clk, .k_clk_n, .c_clk, .c_clk_n);
    ddr_sram_clock_and_command_port u_dut
    (
        .core_clk, .reset, .k_clk, .k_clk_n, .c_clk, .c_clk_n, .single_clock_mode,
        .load_strobe_n, .read_not_write, .address, .byte_write_select_n, .data_in,
        .data_out, .data_oe, .echo_clock, .echo_clock_n
    );
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cycle_count++;
        if (cycle_count == 2000)
        begin
            failures++;
            finish_test();
        end
    end
    task automatic check(input logic [17:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Command on one K rise, beats on the following K_n and K rises.
    task automatic xfer(input logic rd, input logic [19:0] a, input logic [17:0] d0, d1,
        input logic [1:0] bw);
        @(posedge k_clk);
        repeat (3) @(negedge core_clk);
        load_strobe_n = 1'b0;
        read_not_write = rd;
        address = a;
        data_in = d0;
        byte_write_select_n = bw;
        @(posedge k_clk);
        repeat (3) @(negedge core_clk);
        load_strobe_n = 1'b1;
        address = ~a;
        @(posedge k_clk_n);
        repeat (3) @(negedge core_clk);
        data_in = d1;
        @(posedge k_clk);
        @(negedge core_clk);
        if (rd)
            check(data_out, d0);
        repeat (2) @(negedge core_clk);
        data_in = ~d1;
        byte_write_select_n = 2'h3;
        @(posedge k_clk_n);
        @(negedge core_clk);
        if (rd)
            check(data_out, d1);
    endtask
    // The pins pass two synchronising stages and a register, so wait for the echo to settle.
    task automatic echo_check();
        @(posedge k_clk_n);
        repeat (4) @(negedge core_clk);
        check({16'h0000, echo_clock, echo_clock_n}, 18'h00001);
        @(posedge k_clk);
        repeat (4) @(negedge core_clk);
        check({16'h0000, echo_clock, echo_clock_n}, 18'h00002);
        $display("echo check done");
    endtask
    task automatic test_rw();
        xfer(1'b0, 20'h00005, 18'h2A5A5, 18'h15A5A, 2'h0);
        xfer(1'b1, 20'h00005, 18'h2A5A5, 18'h15A5A, 2'h0);
        xfer(1'b1, 20'h00004, 18'h15A5A, 18'h2A5A5, 2'h0);
        repeat (12) @(negedge core_clk);
        check({17'h00000, data_oe}, 18'h00000);
        $display("test_rw done");
    endtask
    task automatic test_bytes();
        logic [17:0] exp;
        for (int bw = 0; bw < 4; bw++)
        begin
            exp = {bw[1] ? 9'h000 : 9'h1FF, bw[0] ? 9'h000 : 9'h1FF};
            xfer(1'b0, 20'h0000A, 18'h00000, 18'h00000, 2'h0);
            xfer(1'b0, 20'h0000A, 18'h3FFFF, 18'h3FFFF, bw[1:0]);
            xfer(1'b1, 20'h0000A, exp, exp, 2'h3);
        end
        $display("test_bytes done");
    endtask
    task automatic test_single();
        out_clk_en = 1'b0;
        single_clock_mode = 1'b1;
        repeat (20) @(negedge core_clk);
        echo_check();
        xfer(1'b1, 20'h00005, 18'h2A5A5, 18'h15A5A, 2'h0);
        single_clock_mode = 1'b0;
        out_clk_en = 1'b1;
        $display("test_single done");
    endtask
    task automatic finish_test();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        reset = 1'b1;
        out_clk_en = 1'b1;
        single_clock_mode = 1'b0;
        load_strobe_n = 1'b1;
        read_not_write = 1'b0;
        address = 20'h00000;
        byte_write_select_n = 2'h3;
        data_in = 18'h00000;
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        echo_check();
        test_rw();
        test_bytes();
        test_single();
        finish_test();
    end
endmodule

// ==== verilog/beat_buffer.sv ====
// Two-entry valid/ready buffer for write beats.
// Assumes both sides run on core_clk.
`timescale 1ns/1ps
module beat_buffer
(
    input wire logic core_clk,
    input wire logic reset,
    input wire sram_port_pkg::beat_type in_beat,
    input wire logic in_valid,
    output logic in_ready,
    output sram_port_pkg::beat_type out_beat,
    output logic out_valid,
    input wire logic out_ready
);
    sram_port_pkg::beat_type mem_q [2];
    sram_port_pkg::beat_type mem_d [2];
    logic wp_q, wp_d, rp_q, rp_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb
    begin
        push = in_valid && (cnt_q != 2'h2);
        pop = out_ready && (cnt_q != 2'h0);
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (push)
        begin
            mem_d[wp_q] = in_beat;
            wp_d = ~wp_q;
        end
        if (pop)
        begin
            rp_d = ~rp_q;
        end
        if (push && !pop)
        begin
            cnt_d = cnt_q + 2'h1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end

    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_beat = mem_q[rp_q];
endmodule

// ==== verilog/ddr_sram_clock_and_command_port.sv ====
// Device side of a DDR SRAM clock and command port, modelled on core_clk.
// Assumes link clocks are far slower than core_clk; all pins are synchronised.
`timescale 1ns/1ps
module ddr_sram_clock_and_command_port
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic single_clock_mode,
    input wire logic load_strobe_n,
    input wire logic read_not_write,
    input wire logic [sram_port_pkg::ADDR_W-1:0] address,
    input wire logic [sram_port_pkg::BYTES-1:0] byte_write_select_n,
    input wire logic [sram_port_pkg::DATA_W-1:0] data_in,
    output logic [sram_port_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    output logic echo_clock,
    output logic echo_clock_n
);
    localparam int AW = sram_port_pkg::ADDR_W;
    localparam int DW = sram_port_pkg::DATA_W;
    localparam int BW = sram_port_pkg::BYTE_W;
    localparam int NB = sram_port_pkg::BYTES;
    localparam int MAW = sram_port_pkg::MEM_AW;

    typedef enum {IDLE, WRITE_BURST, READ_BURST} state_type;

    // Two-stage synchronisers for all pins.
    logic [3:0] clk_s1_q, clk_s2_q, clk_s3_q;
    logic mode_s1_q, mode_s2_q;
    logic ld_s1_q, ld_s2_q, rw_s1_q, rw_s2_q;
    logic [AW-1:0] addr_s1_q, addr_s2_q;
    logic [NB-1:0] bws_s1_q, bws_s2_q;
    logic [DW-1:0] din_s1_q, din_s2_q;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            clk_s1_q <= 4'h0;
            clk_s2_q <= 4'h0;
            clk_s3_q <= 4'h0;
            mode_s1_q <= 1'b0;
            mode_s2_q <= 1'b0;
            ld_s1_q <= 1'b1;
            ld_s2_q <= 1'b1;
            rw_s1_q <= 1'b0;
            rw_s2_q <= 1'b0;
            addr_s1_q <= '0;
            addr_s2_q <= '0;
            bws_s1_q <= '1;
            bws_s2_q <= '1;
            din_s1_q <= '0;
            din_s2_q <= '0;
        end
        else
        begin
            clk_s1_q <= {c_clk_n, c_clk, k_clk_n, k_clk};
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            mode_s1_q <= single_clock_mode;
            mode_s2_q <= mode_s1_q;
            ld_s1_q <= load_strobe_n;
            ld_s2_q <= ld_s1_q;
            rw_s1_q <= read_not_write;
            rw_s2_q <= rw_s1_q;
            addr_s1_q <= address;
            addr_s2_q <= addr_s1_q;
            bws_s1_q <= byte_write_select_n;
            bws_s2_q <= bws_s1_q;
            din_s1_q <= data_in;
            din_s2_q <= din_s1_q;
        end
    end

    logic k_rise, kn_rise, c_rise, cn_rise;
    logic launch_rise, launch_n_rise;
    logic [3:0] rise;

    always_comb
    begin
        rise = clk_s2_q & ~clk_s3_q;
        k_rise = rise[0];
        kn_rise = rise[1];
        c_rise = rise[2];
        cn_rise = rise[3];
        launch_rise = mode_s2_q ? k_rise : c_rise;
        launch_n_rise = mode_s2_q ? kn_rise : cn_rise;
    end

    // Write beats pass a two-entry buffer before the array.
    sram_port_pkg::beat_type wr_in, wr_out;
    logic wr_in_valid, wr_in_ready, wr_out_valid, wr_out_ready;
    logic [AW-1:0] wr_addr_fifo_q [2];
    logic wr_aw_q, wr_ar_q;

    beat_buffer u_beat_buffer
    (
        .core_clk(core_clk),
        .reset(reset),
        .in_beat(wr_in),
        .in_valid(wr_in_valid),
        .in_ready(wr_in_ready),
        .out_beat(wr_out),
        .out_valid(wr_out_valid),
        .out_ready(wr_out_ready)
    );

    logic [DW-1:0] mem_q [sram_port_pkg::DEPTH];
    state_type state_q, state_d;
    logic [AW-1:0] base_q, base_d;
    logic beat_q, beat_d;
    logic [DW-1:0] dout_q, dout_d;
    logic oe_q, oe_d;
    logic cq_q, cq_d, cqn_q, cqn_d;
    logic [AW-1:0] beat_addr;
    logic [MAW-1:0] rd_index, wr_index;
    logic wr_take;

    always_comb
    begin
        state_d = state_q;
        base_d = base_q;
        beat_d = beat_q;
        dout_d = dout_q;
        oe_d = oe_q;
        cq_d = cq_q;
        cqn_d = cqn_q;
        wr_take = 1'b0;
        beat_addr = {base_q[AW-1:1], base_q[0] ^ beat_q};
        rd_index = beat_addr[MAW-1:0];
        if (launch_rise)
        begin
            cq_d = 1'b1;
            cqn_d = 1'b0;
        end
        else if (launch_n_rise)
        begin
            cq_d = 1'b0;
            cqn_d = 1'b1;
        end
        unique case (state_q)
            IDLE:
            begin
                if (k_rise && !ld_s2_q)
                begin
                    base_d = addr_s2_q;
                    beat_d = 1'b0;
                    state_d = rw_s2_q ? READ_BURST : WRITE_BURST;
                end
            end
            WRITE_BURST:
            begin
                if ((kn_rise || k_rise) && wr_in_ready)
                begin
                    wr_take = 1'b1;
                    beat_d = ~beat_q;
                    if (beat_q)
                    begin
                        state_d = IDLE;
                    end
                end
            end
            READ_BURST:
            begin
                if (launch_rise || launch_n_rise)
                begin
                    dout_d = mem_q[rd_index];
                    oe_d = 1'b1;
                    beat_d = ~beat_q;
                    if (beat_q)
                    begin
                        state_d = IDLE;
                    end
                end
            end
        endcase
        if (state_q != READ_BURST && (launch_rise || launch_n_rise))
        begin
            oe_d = 1'b0;
        end
        wr_in.data = din_s2_q;
        wr_in.byte_write_select_n = bws_s2_q;
        wr_in_valid = wr_take;
        wr_out_ready = wr_out_valid;
        wr_index = wr_addr_fifo_q[wr_ar_q][MAW-1:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state_q <= IDLE;
            base_q <= '0;
            beat_q <= 1'b0;
            dout_q <= sram_port_pkg::DATA_RESET;
            oe_q <= 1'b0;
            cq_q <= 1'b0;
            cqn_q <= 1'b0;
            wr_aw_q <= 1'b0;
            wr_ar_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            base_q <= base_d;
            beat_q <= beat_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            cq_q <= cq_d;
            cqn_q <= cqn_d;
            if (wr_take)
            begin
                wr_addr_fifo_q[wr_aw_q] <= beat_addr;
                wr_aw_q <= ~wr_aw_q;
            end
            if (wr_out_valid)
            begin
                wr_ar_q <= ~wr_ar_q;
            end
        end
    end

    // Array update; deselected bytes keep their old contents.
    always_ff @(posedge core_clk)
    begin
        if (wr_out_valid)
        begin
            for (int b = 0; b < NB; b++)
            begin
                if (!wr_out.byte_write_select_n[b])
                begin
                    mem_q[wr_index][b*BW +: BW] <= wr_out.data[b*BW +: BW];
                end
            end
        end
    end

    assign data_out = dout_q;
    assign data_oe = oe_q;
    assign echo_clock = cq_q;
    assign echo_clock_n = cqn_q;
endmodule

// ==== verilog/sram_port_pkg.sv ====
// Constants and carrier types for the DDR SRAM clock and command port.
// Assumes a single core clock; all link clocks are sampled inputs.
// Function
// - Direction high reads, low writes, under strobe
// - Read data launched on both output clocks
// - Address and control sampled on positive input clock rise
// - Accesses start on positive input clock rise
// - Write data captured on both input clocks
// - Single clock mode launches on input clocks
// - Echo clocks follow the output clocks
// - Single clock mode echoes follow input clocks
// - Strobe low starts two-word burst
// - Data outputs released when not reading
// - Byte selects gate nine-bit bytes per beat
// - Low address bit drives linear burst counter
package sram_port_pkg;
    localparam int DATA_W = 18;
    localparam int ADDR_W = 20;
    localparam int BYTE_W = 9;
    localparam int BYTES = 2;
    localparam int DEPTH = 16;
    localparam int MEM_AW = 4;
    localparam int BURST_LEN = 2;
    localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [BYTES-1:0] byte_write_select_n;
    } beat_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic read;
    } command_type;
endpackage
